// File: design/epi_pkg.sv
// shared constants for the external pin request block
package epi_pkg;
  // register offsets on the i/o instruction path
  localparam logic [7:0] OFF_SENSE_STATUS = 8'h34;
  localparam logic [7:0] OFF_PENDING = 8'h3a;
  localparam logic [7:0] OFF_ENABLE = 8'h3b;
  localparam logic [7:0] OFF_SENSE_CTRL = 8'h35;
  // data-space accesses see every register this far up
  localparam logic [7:0] DSPACE_BIAS = 8'h20;
  // highest address reachable by i/o instructions
  localparam logic [7:0] IO_TOP = 8'h3f;
  // reset values
  localparam logic [7:0] RST_SENSE_STATUS = 8'h00;
  localparam logic [7:0] RST_PENDING = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_SENSE_CTRL = 8'h00;
  // field positions
  localparam int BIT_PIN_ONE = 7;
  localparam int BIT_PIN_ZERO = 6;
  localparam int BIT_PIN_TWO = 5;
  localparam int BIT_PIN_TWO_POLARITY = 6;
  localparam int SENSE_ZERO_LSB = 0;
  localparam int SENSE_ONE_LSB = 2;
  // sense field encodings
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_ANY_CHANGE = 2'h1;
  localparam logic [1:0] SENSE_FALLING = 2'h2;
  localparam logic [1:0] SENSE_RISING = 2'h3;
  // vector numbers handed back by the core on entry
  localparam logic [1:0] VEC_PIN_ZERO = 2'h0;
  localparam logic [1:0] VEC_PIN_ONE = 2'h1;
  localparam logic [1:0] VEC_PIN_TWO = 2'h2;
  // timing: clock period and least pulse width on pin two
  localparam int CLK_PERIOD_NS = 4;
  localparam int PIN_TWO_PULSE_NS = 50;
  localparam int PIN_TWO_PULSE_CYC =
    (PIN_TWO_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // cycles from a pin change to the settled sample
  localparam int SYNC_LATENCY_CYC = 3;
endpackage : epi_pkg

// File: design/epi_pin_irq.sv
// Summary of operation
// - pin zero request needs global and pin enable
// - pin zero sampled; pulses of two cycles or more caught
// - bits 1:0 pick pin zero trigger
// - bit 6 picks pin two edge polarity
// - pin two edges caught; 50 ns pulses count
// - enables at bits 7,6,5, reset zero
// - pin activity counts even when pin drives out
// - each pin has its own vector line
// - events set pending bits 7,6,5
// - vector entry clears the matching pending bit
// - writing one clears pending, zero keeps
// - level mode pending always reads zero
// - deep sleep with pin two off clamps input
// - offsets 0x34,0x35,0x3a,0x3b, plus 0x20 data space
// - bits 3:2 pick pin one trigger
// - level and pin two wake without i/o clock
`timescale 1ns/1ns
`default_nettype none
module epi_pin_irq (
  // clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // register access from the core
  input wire logic IO_SPACE,
  input wire logic [7:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WR_DATA,
  output logic [7:0] RD_DATA,
  // request pins
  input wire logic REQUEST_PIN_ZERO,
  input wire logic REQUEST_PIN_ONE,
  input wire logic REQUEST_PIN_TWO,
  // core side
  input wire logic CORE_GLOBAL_IE,
  input wire logic VECTOR_TAKEN,
  input wire logic [1:0] VECTOR_ID,
  input wire logic DEEP_SLEEP,
  output logic [2:0] IRQ_REQ,
  output logic WAKE_ASYNC
);

  // per-pin vectors are indexed 0 = pin zero, 1 = pin one, 2 = pin two
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] stable;
    logic [2:0] pending;
    logic [2:0] enable;
    logic [3:0] sense;
    logic polarity;
    logic [7:0] rdata;
  } epi_state_t;

  epi_state_t state_reg;
  epi_state_t state_next;

  logic [2:0] pin_raw;
  logic [2:0] edge_hit;
  logic [2:0] level_mode;
  logic [2:0] ack_clr;
  logic [1:0] mode [3];
  logic clamp_two;
  logic hit_status;
  logic hit_pending;
  logic hit_enable;
  logic hit_ctrl;

  // trigger decode shared by all pins
  function automatic logic sense_hit(input logic [1:0] m,
                                     input logic prev,
                                     input logic cur);
    logic r;
    r = 1'b0;
    unique case (m)
      epi_pkg::SENSE_LOW_LEVEL: r = 1'b0;
      epi_pkg::SENSE_ANY_CHANGE: r = prev ^ cur;
      epi_pkg::SENSE_FALLING: r = prev & ~cur;
      epi_pkg::SENSE_RISING: r = ~prev & cur;
    endcase
    return r;
  endfunction

  // address match on either path; i/o path stops at the top of i/o space
  function automatic logic addr_hit(input logic io,
                                    input logic [7:0] a,
                                    input logic [7:0] off);
    logic r;
    r = 1'b0;
    if (io) begin
      r = (a <= epi_pkg::IO_TOP) && (a == off);
    end else begin
      r = (a == 8'(off + epi_pkg::DSPACE_BIAS));
    end
    return r;
  endfunction

  // register decode
  always_comb begin
    hit_status = addr_hit(IO_SPACE, ADDR, epi_pkg::OFF_SENSE_STATUS);
    hit_pending = addr_hit(IO_SPACE, ADDR, epi_pkg::OFF_PENDING);
    hit_enable = addr_hit(IO_SPACE, ADDR, epi_pkg::OFF_ENABLE);
    hit_ctrl = addr_hit(IO_SPACE, ADDR, epi_pkg::OFF_SENSE_CTRL);
  end

  // pin two's buffer is shut in deep sleep unless its request is enabled;
  // the clamp looks like a falling input, so it can set the flag
  assign clamp_two = DEEP_SLEEP & ~state_reg.enable[2];

  // pins are read straight, with no regard to port direction
  assign pin_raw = {REQUEST_PIN_TWO & ~clamp_two,
                    REQUEST_PIN_ONE,
                    REQUEST_PIN_ZERO};

  // effective trigger mode per pin; pin two only ever sees edges
  always_comb begin
    mode[0] = state_reg.sense[epi_pkg::SENSE_ZERO_LSB +: 2];
    mode[1] = state_reg.sense[epi_pkg::SENSE_ONE_LSB +: 2];
    mode[2] = state_reg.polarity ? epi_pkg::SENSE_RISING
                                 : epi_pkg::SENSE_FALLING;
  end

  // a change counts once the second and third stages agree, so edges
  // are taken from the settled value against the previous settled value
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      always_comb begin
        level_mode[gi] = (mode[gi] == epi_pkg::SENSE_LOW_LEVEL);
        edge_hit[gi] = (state_reg.sync2[gi] == state_reg.sync3[gi]) &&
                       sense_hit(mode[gi], state_reg.stable[gi],
                                 state_reg.sync3[gi]);
      end
    end
  endgenerate

  // vector entry clears the flag of the vector taken
  always_comb begin
    ack_clr = 3'h0;
    if (VECTOR_TAKEN) begin
      if (VECTOR_ID == epi_pkg::VEC_PIN_ZERO) begin
        ack_clr[0] = 1'b1;
      end
      if (VECTOR_ID == epi_pkg::VEC_PIN_ONE) begin
        ack_clr[1] = 1'b1;
      end
      if (VECTOR_ID == epi_pkg::VEC_PIN_TWO) begin
        ack_clr[2] = 1'b1;
      end
    end
  end

  // next-state logic for the whole block
  always_comb begin
    logic [2:0] clr;
    state_next = state_reg;
    clr = ack_clr;
    // three-stage sampling of every pin
    state_next.sync1 = pin_raw;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    // settled value moves only when the last two stages agree
    for (int i = 0; i < 3; i++) begin
      if (state_reg.sync2[i] == state_reg.sync3[i]) begin
        state_next.stable[i] = state_reg.sync3[i];
      end
    end
    // register writes
    if (WR_EN && hit_enable) begin
      state_next.enable[0] = WR_DATA[epi_pkg::BIT_PIN_ZERO];
      state_next.enable[1] = WR_DATA[epi_pkg::BIT_PIN_ONE];
      state_next.enable[2] = WR_DATA[epi_pkg::BIT_PIN_TWO];
    end
    if (WR_EN && hit_ctrl) begin
      state_next.sense = WR_DATA[3:0];
    end
    if (WR_EN && hit_status) begin
      state_next.polarity = WR_DATA[epi_pkg::BIT_PIN_TWO_POLARITY];
    end
    if (WR_EN && hit_pending) begin
      clr[0] = clr[0] | WR_DATA[epi_pkg::BIT_PIN_ZERO];
      clr[1] = clr[1] | WR_DATA[epi_pkg::BIT_PIN_ONE];
      clr[2] = clr[2] | WR_DATA[epi_pkg::BIT_PIN_TWO];
    end
    // set wins over clear so an event landing on a clear is kept
    for (int i = 0; i < 3; i++) begin
      if (edge_hit[i]) begin
        state_next.pending[i] = 1'b1;
      end else if (clr[i]) begin
        state_next.pending[i] = 1'b0;
      end
      // level mode keeps the flag down; the request follows the pin
      if (level_mode[i]) begin
        state_next.pending[i] = 1'b0;
      end
    end
    // registered read data; unmapped addresses read zero
    state_next.rdata = 8'h00;
    if (RD_EN) begin
      if (hit_enable) begin
        state_next.rdata[epi_pkg::BIT_PIN_ZERO] = state_reg.enable[0];
        state_next.rdata[epi_pkg::BIT_PIN_ONE] = state_reg.enable[1];
        state_next.rdata[epi_pkg::BIT_PIN_TWO] = state_reg.enable[2];
      end
      if (hit_pending) begin
        state_next.rdata[epi_pkg::BIT_PIN_ZERO] = state_reg.pending[0];
        state_next.rdata[epi_pkg::BIT_PIN_ONE] = state_reg.pending[1];
        state_next.rdata[epi_pkg::BIT_PIN_TWO] = state_reg.pending[2];
      end
      if (hit_ctrl) begin
        state_next.rdata[3:0] = state_reg.sense;
      end
      if (hit_status) begin
        state_next.rdata[epi_pkg::BIT_PIN_TWO_POLARITY] = state_reg.polarity;
      end
    end
  end

  // state register
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_reg.sync1 <= 3'h0;
      state_reg.sync2 <= 3'h0;
      state_reg.sync3 <= 3'h0;
      state_reg.stable <= 3'h0;
      state_reg.pending <= epi_pkg::RST_PENDING[7:5];
      state_reg.enable <= epi_pkg::RST_ENABLE[7:5];
      state_reg.sense <= epi_pkg::RST_SENSE_CTRL[3:0];
      state_reg.polarity <= epi_pkg::RST_SENSE_STATUS[6];
      state_reg.rdata <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // one request line per vector, gated by both enables
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      IRQ_REQ[i] = CORE_GLOBAL_IE & state_reg.enable[i] &
                   (level_mode[i] ? ~state_reg.stable[i]
                                  : state_reg.pending[i]);
    end
  end

  // wake path works from the raw pins, no clock needed; pin two wakes
  // on its post-edge level since a stopped clock cannot see the edge
  assign WAKE_ASYNC =
    (state_reg.enable[0] & level_mode[0] & ~REQUEST_PIN_ZERO) |
    (state_reg.enable[1] & level_mode[1] & ~REQUEST_PIN_ONE) |
    (state_reg.enable[2] & (REQUEST_PIN_TWO == state_reg.polarity));

  assign RD_DATA = state_reg.rdata;

  // checks

  chk_req_gating: assert property (@(posedge CLOCK) disable iff (!NRST)
    IRQ_REQ[0] |-> (CORE_GLOBAL_IE && state_reg.enable[0]))
    else $error("pin zero request without both enables");

  chk_edge_sets: assert property (@(posedge CLOCK) disable iff (!NRST)
    (edge_hit[0] && !level_mode[0]) |=> state_reg.pending[0])
    else $error("pin zero edge did not set pending");

  chk_fall_detect: assert property (@(posedge CLOCK) disable iff (!NRST)
    (mode[0] == epi_pkg::SENSE_FALLING && state_reg.stable[0] &&
     !state_reg.sync2[0] && !state_reg.sync3[0]) |-> edge_hit[0])
    else $error("settled falling pin zero not detected");

  chk_level_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
    level_mode[1] |=> !state_reg.pending[1])
    else $error("pending set in level mode");

  chk_w1c_clear: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WR_EN && hit_pending && WR_DATA[epi_pkg::BIT_PIN_TWO] && !edge_hit[2])
    |=> !state_reg.pending[2])
    else $error("write one did not clear pin two pending");

  chk_w0_keep: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WR_EN && hit_pending && !WR_DATA[epi_pkg::BIT_PIN_TWO] &&
     state_reg.pending[2] && !ack_clr[2]) |=> state_reg.pending[2])
    else $error("write zero changed pin two pending");

  chk_rise_pol: assert property (@(posedge CLOCK) disable iff (!NRST)
    (state_reg.polarity && !state_reg.stable[2] && state_reg.sync2[2] &&
     state_reg.sync3[2]) |=> state_reg.pending[2])
    else $error("rising pin two edge missed");

  chk_ack_clear: assert property (@(posedge CLOCK) disable iff (!NRST)
    (VECTOR_TAKEN && VECTOR_ID == epi_pkg::VEC_PIN_ONE && !edge_hit[1])
    |=> !state_reg.pending[1])
    else $error("vector entry did not clear pin one pending");

  chk_read_flags: assert property (@(posedge CLOCK) disable iff (!NRST)
    (RD_EN && hit_pending) |=>
    RD_DATA[epi_pkg::BIT_PIN_ONE] == $past(state_reg.pending[1]))
    else $error("pending read returned wrong value");

  chk_enable_write: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WR_EN && hit_enable) |=>
    state_reg.enable[2] == $past(WR_DATA[epi_pkg::BIT_PIN_TWO]))
    else $error("enable write not stored");

  chk_clamp_two: assert property (@(posedge CLOCK) disable iff (!NRST)
    clamp_two |=> !state_reg.sync1[2])
    else $error("pin two not clamped in deep sleep");

  chk_rdata_idle: assert property (@(posedge CLOCK) disable iff (!NRST)
    !RD_EN |=> RD_DATA == 8'h00)
    else $error("read data not zero without a read");

  chk_level_req: assert property (@(posedge CLOCK) disable iff (!NRST)
    (level_mode[0] && CORE_GLOBAL_IE && state_reg.enable[0] &&
     !state_reg.stable[0]) |-> IRQ_REQ[0])
    else $error("settled low level gave no pin zero request");

  chk_pin1_gating: assert property (@(posedge CLOCK) disable iff (!NRST)
    IRQ_REQ[1] |-> (CORE_GLOBAL_IE && state_reg.enable[1]))
    else $error("pin one request without both enables");

  chk_pin2_gating: assert property (@(posedge CLOCK) disable iff (!NRST)
    IRQ_REQ[2] |-> (CORE_GLOBAL_IE && state_reg.enable[2]))
    else $error("pin two request without both enables");

  chk_fall_pol: assert property (@(posedge CLOCK) disable iff (!NRST)
    (!state_reg.polarity && state_reg.stable[2] && !state_reg.sync2[2] &&
     !state_reg.sync3[2]) |=> state_reg.pending[2])
    else $error("falling pin two edge missed");

  chk_sense_write: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WR_EN && hit_ctrl) |=> state_reg.sense == $past(WR_DATA[3:0]))
    else $error("sense write not stored");

  chk_rise_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
    (mode[0] == epi_pkg::SENSE_RISING && !state_reg.stable[0] &&
     state_reg.sync2[0] && state_reg.sync3[0]) |-> edge_hit[0])
    else $error("settled rising pin zero not detected");

  chk_wake_level: assert property (@(posedge CLOCK) disable iff (!NRST)
    (state_reg.enable[0] && level_mode[0] && !REQUEST_PIN_ZERO) |->
    WAKE_ASYNC)
    else $error("enabled low pin zero did not wake");

endmodule : epi_pin_irq
`default_nettype wire

// File: tb/epi_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module epi_pin_model (
  // bench side
  input wire logic CLOCK,
  input wire logic [2:0] LEVEL,
  // request pins, low from time zero so reset sees no change
  output var logic PIN_ZERO = 1'b0,
  output var logic PIN_ONE = 1'b0,
  output var logic PIN_TWO = 1'b0
);
  // a source only moves its pin on a falling edge, then holds it
  always @(negedge CLOCK) begin
    {PIN_TWO, PIN_ONE, PIN_ZERO} <= LEVEL;
  end
endmodule // epi_pin_model
`default_nettype wire

// File: tb/test_external_pin_interrupts.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_external_pin_interrupts;
  logic clock = 0, nrst = 0, ds = 0, wr_en = 0, rd_en = 0, ie = 0;
  logic vtk = 0, slp = 0, pol, p0, p1, p2, wake;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, rq, en, ex;
  logic [2:0] level = 3'h0, irq, old;
  logic [3:0] sn;
  logic [1:0] vid = 2'h0;
  int bad_count = 0, n_compared = 0;
  initial forever #2 clock = ~clock;
  epi_pin_model u_epi_pin_model (.CLOCK(clock), .LEVEL(level),
    .PIN_ZERO(p0), .PIN_ONE(p1), .PIN_TWO(p2));
  epi_pin_irq u_epi_pin_irq (.CLOCK(clock), .NRST(nrst), .IO_SPACE(!ds),
    .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en), .WR_DATA(wdat),
    .RD_DATA(rdat), .REQUEST_PIN_ZERO(p0), .REQUEST_PIN_ONE(p1),
    .REQUEST_PIN_TWO(p2), .CORE_GLOBAL_IE(ie), .VECTOR_TAKEN(vtk),
    .VECTOR_ID(vid), .DEEP_SLEEP(slp), .IRQ_REQ(irq), .WAKE_ASYNC(wake));
  // data-space accesses add the bias, so both paths share the random loop; other tests use the i/o path
  function automatic logic [7:0] map(input logic [7:0] a);
    return ds ? a + epi_pkg::DSPACE_BIAS : a;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = map(a);
    wdat = d;
    wr_en = 1;
    @(negedge clock);
    wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    addr = map(a);
    rd_en = 1;
    @(negedge clock);
    rd_en = 0;
    rq = rdat;
  endtask
  task automatic settle;
    repeat (10) @(negedge clock);
  endtask
  task automatic vec(input logic [1:0] id);
    @(negedge clock);
    vid = id;
    vtk = 1;
    @(negedge clock);
    vtk = 0;
  endtask
  // expected flag for one synchronous pin after a level step
  function automatic logic flag(input logic [1:0] m, input logic a, b);
    return (m == epi_pkg::SENSE_ANY_CHANGE && a != b) ||
      (m == epi_pkg::SENSE_FALLING && a && !b) ||
      (m == epi_pkg::SENSE_RISING && !a && b);
  endfunction
  // every pin toggles once with edge sensing, so all three flags rise
  task automatic make_all;
    wr(epi_pkg::OFF_SENSE_CTRL, 8'h05);
    wr(epi_pkg::OFF_SENSE_STATUS, {1'b0, !level[2], 6'h0});
    wr(epi_pkg::OFF_PENDING, 8'he0);
    level = ~level;
    settle();
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // a hung run counts as a mismatch
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h856a));
    repeat (16) @(negedge clock);
    nrst = 1;
    rd(epi_pkg::OFF_SENSE_STATUS); `CHK(rq, epi_pkg::RST_SENSE_STATUS)
    rd(epi_pkg::OFF_PENDING); `CHK(rq, epi_pkg::RST_PENDING)
    rd(epi_pkg::OFF_ENABLE); `CHK(rq, epi_pkg::RST_ENABLE)
    rd(epi_pkg::OFF_SENSE_CTRL); `CHK(rq, epi_pkg::RST_SENSE_CTRL)
    // unmapped places ignore writes and read zero
    wr(8'h36, 8'hff);
    rd(8'h36); `CHK(rq, 8'h00)
    for (int i = 0; i < 60; i++) begin
      ds = 1'($urandom);
      en = 8'($urandom) & 8'he0;
      sn = 4'($urandom);
      pol = 1'($urandom);
      ie = 1'($urandom);
      old = level;
      wr(epi_pkg::OFF_ENABLE, 8'h00);
      wr(epi_pkg::OFF_SENSE_STATUS, {1'b0, pol, 6'h0});
      wr(epi_pkg::OFF_SENSE_CTRL, {4'h0, sn});
      wr(epi_pkg::OFF_PENDING, 8'he0);
      wr(epi_pkg::OFF_ENABLE, en);
      level = 3'($urandom);
      settle();
      ex = {flag(sn[3:2], old[1], level[1]), flag(sn[1:0], old[0], level[0]),
        pol ? (!old[2] && level[2]) : (old[2] && !level[2]), 5'h0};
      rd(epi_pkg::OFF_PENDING); `CHK(rq, ex)
      rd(epi_pkg::OFF_ENABLE); `CHK(rq, en)
      rd(epi_pkg::OFF_SENSE_STATUS); `CHK(rq[6], pol)
      old = {ie & en[5] & ex[5],
        ie & en[7] & (sn[3:2] == 2'h0 ? !level[1] : ex[7]),
        ie & en[6] & (sn[1:0] == 2'h0 ? !level[0] : ex[6])};
      `CHK(irq, old)
    end
    ds = 0;
    // a three-cycle pulse in any-change mode must leave a flag
    wr(epi_pkg::OFF_SENSE_CTRL, 8'h01);
    wr(epi_pkg::OFF_PENDING, 8'he0);
    level[0] = ~level[0];
    repeat (3) @(negedge clock);
    level[0] = ~level[0];
    settle();
    rd(epi_pkg::OFF_PENDING); `CHK(rq[6], 1'b1)
    // flags clear by writing one or by vector entry, zero keeps them
    make_all();
    wr(epi_pkg::OFF_PENDING, 8'h00);
    rd(epi_pkg::OFF_PENDING); `CHK(rq, 8'he0)
    vec(epi_pkg::VEC_PIN_ONE);
    rd(epi_pkg::OFF_PENDING); `CHK(rq, 8'h60)
    wr(epi_pkg::OFF_PENDING, 8'h40);
    rd(epi_pkg::OFF_PENDING); `CHK(rq, 8'h20)
    vec(epi_pkg::VEC_PIN_TWO);
    rd(epi_pkg::OFF_PENDING); `CHK(rq, 8'h00)
    make_all();
    vec(epi_pkg::VEC_PIN_ZERO);
    rd(epi_pkg::OFF_PENDING); `CHK(rq, 8'ha0)
    // clamp in deep sleep turns a high pin two into a falling change
    wr(epi_pkg::OFF_ENABLE, 8'h00);
    wr(epi_pkg::OFF_SENSE_STATUS, 8'h00);
    level[2] = 1;
    settle();
    wr(epi_pkg::OFF_PENDING, 8'he0);
    slp = 1;
    settle();
    rd(epi_pkg::OFF_PENDING); `CHK(rq[5], 1'b1)
    slp = 0;
    // an enabled low level wakes without the clock path
    wr(epi_pkg::OFF_SENSE_CTRL, 8'h00);
    wr(epi_pkg::OFF_ENABLE, 8'h40);
    level[0] = 0;
    settle();
    `CHK(wake, 1'b1)
    report_and_stop();
  end
endmodule // test_external_pin_interrupts
`default_nettype wire
